// >>> verilog/ccd_clock_host.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_clock_host import ccd_pkg::*; #(
  parameter int KW = KHZ_W
) (
  input wire logic sys_clk, // system clock, 10 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic cmd_valid, // order offered
  output logic cmd_ready, // order taken when both high
  input wire logic [2:0] cmd_op, // order kind, ccd_op_e
  input wire logic [3:0] cmd_src, // clock source selector
  input wire logic [2:0] cmd_freq, // frequency code or output select
  input wire logic cmd_family, // main clock family bit
  input wire logic cmd_on, // enable or pulldown on
  input wire logic [KW-1:0] cmd_khz, // core clock in kHz
  input wire logic [2:0] cmd_index, // rate slot or output number
  input wire logic [4:0] cmd_rate, // rate select code
  input wire logic [4:0] cmd_div, // output divider code
  input wire logic [15:0] cmd_addr, // address for a plain read
  input wire logic need_slow, // debounce, detect or pump in use
  output logic done, // order finished pulse
  output logic err, // order refused pulse
  output logic [15:0] rd_data, // last read-back value
  output logic [15:0] dev_addr, // device register address
  output logic [15:0] dev_wdata, // device write data
  output logic dev_wr, // device write request
  output logic dev_rd, // device read request
  input wire logic dev_ack, // device acknowledge
  input wire logic [15:0] dev_rdata // device read data
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_CALC = 5'b00010, ST_PLAN = 5'b00100,
    ST_RUN = 5'b01000, ST_WAIT = 5'b10000
  } ccd_st_e;
  typedef struct packed {
    ccd_st_e st;
    ccd_op_e op;
    logic [3:0] c_src;
    logic [2:0] c_freq;
    logic c_fam;
    logic c_on;
    logic [2:0] c_idx;
    logic [4:0] c_rate;
    logic [4:0] c_div;
    logic [15:0] c_addr;
    logic [15:0] code;
    logic [2:0][15:0] adr;
    logic [2:0][15:0] dat;
    logic [1:0] cnt;
    logic [1:0] idx;
    logic rd;
    logic rdg;
    logic [15:0] rd_adr;
    logic done;
    logic err;
    logic [15:0] rdata;
    logic fpend;
    logic [3:0] main_src;
    logic [2:0] main_freq;
    logic main_fam;
    logic main_on;
    logic [3:0] sec_src;
    logic [2:0] sec_freq;
    logic sec_on;
    logic [3:0] core_src;
    logic [15:0] core_code;
    logic core_on;
    logic [1:0] slow_src;
    logic slow_on;
  } ccd_host_s;
  ccd_host_s s, n;
  logic div_done;
  logic [15:0] div_code;
  logic port_go;
  logic port_done;
  logic [15:0] port_rdata;

  function automatic logic [15:0] mk_clk(input logic fam, input logic [2:0] freq,
                                        input logic on, input logic [3:0] src);
    logic [15:0] v;
    v = '0;
    v[FAM_BIT] = fam;
    v[FREQ_LSB +: 3] = freq;
    v[ON_BIT] = on;
    v[SRC_LSB +: 4] = src;
    return v;
  endfunction

  ccd_khz_div #(.KW(KW)) u_div (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(cmd_valid && s.st == ST_IDLE && cmd_op == OP_CORE),
    .khz(cmd_khz),
    .done(div_done),
    .code(div_code)
  );

  assign port_go = (s.st == ST_RUN);
  ccd_reg_port u_port (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .go(port_go),
    .is_rd(s.rdg),
    .addr(s.rdg ? s.rd_adr : s.adr[s.idx]),
    .wdata(s.dat[s.idx]),
    .done(port_done),
    .rdata(port_rdata),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_wr(dev_wr),
    .dev_rd(dev_rd),
    .dev_ack(dev_ack),
    .dev_rdata(dev_rdata)
  );

  always_comb begin
    logic [15:0] w;
    logic [2:0] lim;
    logic ok;
    logic slow_en;
    w = s.dat[s.idx];
    lim = '0;
    ok = 1'b0;
    slow_en = s.c_on || need_slow;
    n = s;
    n.done = 1'b0;
    n.err = 1'b0;
    case (s.st)
      ST_IDLE: if (cmd_valid) begin
        n.op = ccd_op_e'(cmd_op);
        n.c_src = cmd_src;
        n.c_freq = cmd_freq;
        n.c_fam = cmd_family;
        n.c_on = cmd_on;
        n.c_idx = cmd_index;
        n.c_rate = cmd_rate;
        n.c_div = cmd_div;
        n.c_addr = cmd_addr;
        n.st = (cmd_op == OP_CORE) ? ST_CALC : ST_PLAN;
      end
      ST_CALC: if (div_done) begin
        n.code = div_code;
        n.st = ST_PLAN;
      end
      ST_PLAN: begin
        n.cnt = 2'h1;
        n.idx = 2'h0;
        n.rd = 1'b0;
        case (s.op)
          OP_MAIN: begin
            ok = ccd_src_ok(s.c_src) && s.c_freq <= FREQ_MAX;
            n.adr[0] = ADDR_MAIN;
            n.adr[1] = ADDR_MAIN;
            n.dat[0] = mk_clk(s.c_fam, s.c_freq, s.c_on, s.c_src);
            if (s.main_on && s.c_src == s.main_src &&
                (s.c_freq != s.main_freq || s.c_fam != s.main_fam)) begin
              n.dat[0] = mk_clk(s.main_fam, s.main_freq, 1'b0, s.main_src);
              n.dat[1] = mk_clk(s.c_fam, s.c_freq, s.c_on, s.c_src);
              n.cnt = 2'h2;
            end
          end
          OP_SECOND: begin
            ok = ccd_src_ok(s.c_src) && s.c_freq <= FREQ_MAX;
            n.adr[0] = ADDR_SECOND;
            n.adr[1] = ADDR_SECOND;
            n.dat[0] = mk_clk(1'b0, s.c_freq, s.c_on, s.c_src);
            if (s.sec_on && s.c_src == s.sec_src && s.c_freq != s.sec_freq) begin
              n.dat[0] = mk_clk(1'b0, s.sec_freq, 1'b0, s.sec_src);
              n.dat[1] = mk_clk(1'b0, s.c_freq, s.c_on, s.c_src);
              n.cnt = 2'h2;
            end
          end
          OP_CORE: begin
            ok = ccd_src_ok(s.c_src) && s.code >= CORE_MIN && s.code <= CORE_MAX;
            n.rd = 1'b1;
            n.rd_adr = ADDR_CORE_FSTATE;
            n.adr[0] = ADDR_CORE_FREQ;
            n.dat[0] = s.code;
            n.adr[1] = ADDR_CORE_SEL;
            n.dat[1] = mk_clk(1'b0, 3'h0, s.c_on, s.c_src);
            n.cnt = 2'h2;
            if (s.core_on && s.c_src == s.core_src) begin
              // a source rewrite alone would not drop a running clock
              n.adr[0] = ADDR_CORE_SEL;
              n.dat[0] = mk_clk(1'b0, 3'h0, 1'b0, s.core_src);
              n.adr[1] = ADDR_CORE_FREQ;
              n.dat[1] = s.code;
              n.adr[2] = ADDR_CORE_SEL;
              n.dat[2] = mk_clk(1'b0, 3'h0, s.c_on, s.c_src);
              n.cnt = 2'h3;
            end
          end
          OP_SLOW: begin
            ok = s.c_src[1:0] != SLOW_SRC_RSVD;
            n.adr[0] = ADDR_SLOW;
            n.adr[1] = ADDR_SLOW;
            n.dat[0] = mk_clk(1'b0, 3'h0, slow_en, {2'h0, s.c_src[1:0]});
            if (s.slow_on && s.c_src[1:0] != s.slow_src) begin
              n.dat[0] = mk_clk(1'b0, 3'h0, 1'b0, {2'h0, s.slow_src});
              n.dat[1] = mk_clk(1'b0, 3'h0, slow_en, {2'h0, s.c_src[1:0]});
              n.cnt = 2'h2;
            end
          end
          OP_RATE: begin
            ok = s.c_idx < RATE_SLOTS && ccd_rate_ok(s.c_rate);
            n.adr[0] = RATE_ADDR[s.c_idx];
            n.dat[0] = {11'h000, s.c_rate};
            n.rd = 1'b1;
            n.rd_adr = RATE_STATE_ADDR[s.c_idx];
          end
          OP_OUT: begin
            lim = s.c_idx[0] ? s.sec_freq : s.main_freq;
            ok = s.c_idx[2:1] == 2'h0 && s.c_freq <= OUT_SEL_MAX;
            ok = ok && s.c_freq <= lim;
            if (s.c_on) begin
              ok = ok && !s.c_div[0] && s.c_div >= DIV_MIN && s.c_div <= DIV_MAX;
            end
            n.adr[0] = s.c_idx[0] ? ADDR_OUT_SECOND : ADDR_OUT_MAIN;
            n.dat[0] = '0;
            n.dat[0][OUT_ON_BIT] = s.c_on;
            n.dat[0][DIV_LSB +: 5] = s.c_div;
            n.dat[0][SEL_LSB +: 3] = s.c_freq;
          end
          OP_PAD: begin
            ok = 1'b1;
            n.adr[0] = ADDR_PADS;
            n.dat[0] = '0;
            n.dat[0][PD_BIT] = s.c_on;
          end
          OP_READ: begin
            ok = 1'b1;
            n.cnt = 2'h0;
            n.rd = 1'b1;
            n.rd_adr = s.c_addr;
          end
          default: ok = 1'b0;
        endcase
        n.rdg = (n.cnt == 2'h0);
        n.err = !ok;
        n.st = ok ? ST_RUN : ST_IDLE;
      end
      ST_RUN: begin
        if (!s.rdg && s.adr[s.idx] == ADDR_CORE_FREQ) n.fpend = 1'b1;
        if (!s.rdg && s.adr[s.idx] == ADDR_CORE_SEL) n.fpend = 1'b0;
        n.st = ST_WAIT;
      end
      ST_WAIT: if (port_done) begin
        if (s.rdg) begin
          n.rdata = port_rdata;
          n.done = 1'b1;
          n.st = ST_IDLE;
        end else begin
          // mirror what the device now holds, one write at a time
          case (s.adr[s.idx])
            ADDR_MAIN: begin
              n.main_fam = w[FAM_BIT];
              n.main_freq = w[FREQ_LSB +: 3];
              n.main_on = w[ON_BIT];
              n.main_src = w[SRC_LSB +: 4];
            end
            ADDR_SECOND: begin
              n.sec_freq = w[FREQ_LSB +: 3];
              n.sec_on = w[ON_BIT];
              n.sec_src = w[SRC_LSB +: 4];
            end
            ADDR_CORE_SEL: begin
              n.core_on = w[ON_BIT];
              n.core_src = w[SRC_LSB +: 4];
            end
            ADDR_CORE_FREQ: n.core_code = w;
            ADDR_SLOW: begin
              n.slow_on = w[ON_BIT];
              n.slow_src = w[SRC_LSB +: 2];
            end
            default: n.core_code = s.core_code;
          endcase
          if (s.idx + 2'h1 < s.cnt) begin
            n.idx = s.idx + 2'h1;
            n.st = ST_RUN;
          end else if (s.rd) begin
            n.rdg = 1'b1;
            n.st = ST_RUN;
          end else begin
            n.done = 1'b1;
            n.st = ST_IDLE;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.op <= OP_READ;
      s.main_src <= MAIN_SRC_RST;
      s.main_freq <= MAIN_FREQ_RST;
      s.sec_src <= SEC_SRC_RST;
      s.sec_freq <= SEC_FREQ_RST;
      s.core_src <= CORE_SRC_RST;
      s.slow_src <= SLOW_SRC_RST;
    end else begin
      s <= n;
    end
  end

  assign cmd_ready = (s.st == ST_IDLE);
  assign done = s.done;
  assign err = s.err;
  assign rd_data = s.rdata;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  core_code_range_a: assert property (dev_wr && dev_addr == ADDR_CORE_FREQ |->
    dev_wdata >= CORE_MIN && dev_wdata <= CORE_MAX)
    else $error("core frequency write outside the allowed range");
  core_freq_applied_a: assert property (s.done |-> !s.fpend)
    else $error("core frequency written without a later source write");
  core_same_src_a: assert property ($rose(dev_wr) && dev_addr == ADDR_CORE_FREQ
    && s.core_on |-> s.dat[s.cnt - 2'h1][SRC_LSB +: 4] != s.core_src)
    else $error("core frequency changed on a running clock with the same source");
  main_freq_change_a: assert property ($rose(dev_wr) && dev_addr == ADDR_MAIN
    && s.main_on && dev_wdata[ON_BIT] && dev_wdata[SRC_LSB +: 4] == s.main_src
    |-> dev_wdata[FREQ_LSB +: 3] == s.main_freq && dev_wdata[FAM_BIT] == s.main_fam)
    else $error("main frequency changed while running on the same source");
  second_freq_change_a: assert property ($rose(dev_wr) && dev_addr == ADDR_SECOND
    && s.sec_on && dev_wdata[ON_BIT] && dev_wdata[SRC_LSB +: 4] == s.sec_src
    |-> dev_wdata[FREQ_LSB +: 3] == s.sec_freq)
    else $error("second frequency changed while running on the same source");
  out_div_even_a: assert property (dev_wr && dev_wdata[OUT_ON_BIT] &&
    (dev_addr == ADDR_OUT_MAIN || dev_addr == ADDR_OUT_SECOND)
    |-> !dev_wdata[DIV_LSB] && dev_wdata[DIV_LSB +: 5] >= DIV_MIN)
    else $error("clock output enabled with an odd or too small divider");
  out_sel_limit_a: assert property (dev_wr && dev_addr == ADDR_OUT_MAIN |->
    dev_wdata[SEL_LSB +: 3] <= s.main_freq && dev_wdata[SEL_LSB +: 3] <= OUT_SEL_MAX)
    else $error("main output frequency above main clock frequency");
  slow_forced_a: assert property (s.st == ST_PLAN && s.op == OP_SLOW && need_slow
    && s.c_src[1:0] != SLOW_SRC_RSVD |=> s.dat[s.cnt - 2'h1][ON_BIT])
    else $error("slow clock left off while a user needs it");
endmodule // ccd_clock_host
`default_nettype wire

// >>> verilog/ccd_pkg.sv
`default_nettype none
package ccd_pkg;
  localparam logic [15:0] ADDR_SLOW = 16'h0100;
  localparam logic [15:0] ADDR_MAIN = 16'h0101;
  localparam logic [15:0] ADDR_RATE1 = 16'h0102;
  localparam logic [15:0] ADDR_RATE2 = 16'h0103;
  localparam logic [15:0] ADDR_RATE3 = 16'h0104;
  localparam logic [15:0] ADDR_RSTATE1 = 16'h010a;
  localparam logic [15:0] ADDR_RSTATE2 = 16'h010b;
  localparam logic [15:0] ADDR_RSTATE3 = 16'h010c;
  localparam logic [15:0] ADDR_SECOND = 16'h0112;
  localparam logic [15:0] ADDR_SRATE1 = 16'h0113;
  localparam logic [15:0] ADDR_SRATE2 = 16'h0114;
  localparam logic [15:0] ADDR_SRSTATE1 = 16'h011b;
  localparam logic [15:0] ADDR_SRSTATE2 = 16'h011c;
  localparam logic [15:0] ADDR_CORE_SEL = 16'h0120;
  localparam logic [15:0] ADDR_CORE_FREQ = 16'h0122;
  localparam logic [15:0] ADDR_CORE_FSTATE = 16'h0126;
  localparam logic [15:0] ADDR_CORE_SSTATE = 16'h0127;
  localparam logic [15:0] ADDR_OUT_MAIN = 16'h0149;
  localparam logic [15:0] ADDR_OUT_SECOND = 16'h014a;
  localparam logic [15:0] ADDR_PADS = 16'h014e;
  // rate slots 0..2 are the main domain, 3..4 the second domain
  localparam logic [4:0][15:0] RATE_ADDR =
    {ADDR_SRATE2, ADDR_SRATE1, ADDR_RATE3, ADDR_RATE2, ADDR_RATE1};
  localparam logic [4:0][15:0] RATE_STATE_ADDR =
    {ADDR_SRSTATE2, ADDR_SRSTATE1, ADDR_RSTATE3, ADDR_RSTATE2, ADDR_RSTATE1};
  localparam logic [2:0] RATE_SLOTS = 3'h5;
  localparam int FAM_BIT = 15;
  localparam int FREQ_LSB = 8;
  localparam int ON_BIT = 6;
  localparam int SRC_LSB = 0;
  localparam int OUT_ON_BIT = 15;
  localparam int DIV_LSB = 3;
  localparam int SEL_LSB = 0;
  localparam int PD_BIT = 9;
  localparam logic [3:0] MAIN_SRC_RST = 4'h4;
  localparam logic [2:0] MAIN_FREQ_RST = 3'h4;
  localparam logic [3:0] SEC_SRC_RST = 4'h5;
  localparam logic [2:0] SEC_FREQ_RST = 3'h3;
  localparam logic [3:0] CORE_SRC_RST = 4'h5;
  localparam logic [1:0] SLOW_SRC_RST = 2'h2;
  localparam logic [1:0] SLOW_SRC_RSVD = 2'h3;
  localparam logic [2:0] FREQ_MAX = 3'h4;
  localparam logic [2:0] OUT_SEL_MAX = 3'h3;
  localparam logic [4:0] DIV_MIN = 5'h02;
  localparam logic [4:0] DIV_MAX = 5'h1e;
  // 5.6 MHz and 148 MHz in 1/64 MHz counts
  localparam logic [15:0] CORE_MIN = 16'h0166;
  localparam logic [15:0] CORE_MAX = 16'h2500;
  localparam logic [15:0] CORE_SAT = 16'hffff;
  // kHz * 64 / 1000 = (kHz << 3) / 125
  localparam int KHZ_W = 18;
  localparam int KHZ_SHIFT = 3;
  localparam logic [6:0] KHZ_DEN = 7'h7d;
  typedef enum logic [2:0] {
    OP_MAIN = 3'h0, OP_SECOND = 3'h1, OP_CORE = 3'h2, OP_SLOW = 3'h3,
    OP_RATE = 3'h4, OP_OUT = 3'h5, OP_PAD = 3'h6, OP_READ = 3'h7
  } ccd_op_e;
  function automatic logic ccd_src_ok(input logic [3:0] s);
    case (s)
      4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hf: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic ccd_rate_ok(input logic [4:0] r);
    return (r <= 5'h06) || (r >= 5'h09 && r <= 5'h0e) || (r >= 5'h11 && r <= 5'h13);
  endfunction
endpackage
`default_nettype wire

// >>> verilog/ccd_khz_div.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_khz_div import ccd_pkg::*; #(
  parameter int KW = KHZ_W
) (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic start, // begin a conversion
  input wire logic [KW-1:0] khz, // core clock in kHz
  output logic done, // result ready pulse
  output logic [15:0] code // 1/64 MHz count, saturated
);
  localparam int NW = KW + KHZ_SHIFT;
  if (KW < 14 || KW > 24) begin : g_bad_width
    $error("ccd_khz_div: KW must lie in 14..24");
  end
  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] cnt;
    logic [NW-1:0] num;
    logic [7:0] rem;
    logic [NW-1:0] q;
    logic [KW-1:0] khz;
  } ccd_div_s;
  ccd_div_s s, n;
  always_comb begin
    logic [7:0] r2;
    r2 = {s.rem[6:0], s.num[NW-1]};
    n = s;
    n.done = 1'b0;
    if (start && !s.busy) begin
      n.busy = 1'b1;
      n.cnt = 5'(NW);
      n.num = {khz, {KHZ_SHIFT{1'b0}}};
      n.khz = khz;
      n.rem = '0;
      n.q = '0;
    end else if (s.busy) begin
      // restoring division, one quotient bit per cycle, rounds down
      n.num = {s.num[NW-2:0], 1'b0};
      if (r2 >= {1'b0, KHZ_DEN}) begin
        n.rem = r2 - {1'b0, KHZ_DEN};
        n.q = {s.q[NW-2:0], 1'b1};
      end else begin
        n.rem = r2;
        n.q = {s.q[NW-2:0], 1'b0};
      end
      n.cnt = s.cnt - 5'h01;
      if (s.cnt == 5'h01) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign done = s.done;
  assign code = (|s.q[NW-1:16]) ? CORE_SAT : s.q[15:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  core_code_floor_a: assert property (s.done && code != CORE_SAT |->
    (32'(code) * 32'(KHZ_DEN) <= (32'(s.khz) << KHZ_SHIFT)) &&
    ((32'(code) + 32'h0000_0001) * 32'(KHZ_DEN) > (32'(s.khz) << KHZ_SHIFT)))
    else $error("core frequency code is not the rounded-down count");
endmodule // ccd_khz_div
`default_nettype wire

// >>> verilog/ccd_reg_port.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_reg_port import ccd_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic go, // start one access, taken when idle
  input wire logic is_rd, // access is a read
  input wire logic [15:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  output logic done, // access complete pulse
  output logic [15:0] rdata, // read result
  output logic [15:0] dev_addr, // address to device
  output logic [15:0] dev_wdata, // write data to device
  output logic dev_wr, // write request level
  output logic dev_rd, // read request level
  input wire logic dev_ack, // device acknowledge level
  input wire logic [15:0] dev_rdata // device read data
);
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001, PS_REQ = 3'b010, PS_REL = 3'b100
  } ccd_port_e;
  typedef struct packed {
    ccd_port_e st;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic done;
    logic [15:0] rdata;
    logic ack_m;
    logic ack_s;
    logic [15:0] rd_m;
    logic [15:0] rd_s;
  } ccd_port_s;
  ccd_port_s s, n;
  // four-phase handshake: the device may sit on any clock
  always_comb begin
    n = s;
    n.ack_m = dev_ack;
    n.ack_s = s.ack_m;
    n.rd_m = dev_rdata;
    n.rd_s = s.rd_m;
    n.done = 1'b0;
    case (s.st)
      PS_IDLE: if (go) begin
        n.addr = addr;
        n.wdata = wdata;
        n.wr = !is_rd;
        n.rd = is_rd;
        n.st = PS_REQ;
      end
      PS_REQ: if (s.ack_s) begin
        n.rdata = s.rd_s;
        n.wr = 1'b0;
        n.rd = 1'b0;
        n.st = PS_REL;
      end
      PS_REL: if (!s.ack_s) begin
        n.done = 1'b1;
        n.st = PS_IDLE;
      end
      default: n.st = PS_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.st <= PS_IDLE;
    end else begin
      s <= n;
    end
  end
  assign done = s.done;
  assign rdata = s.rdata;
  assign dev_addr = s.addr;
  assign dev_wdata = s.wdata;
  assign dev_wr = s.wr;
  assign dev_rd = s.rd;
endmodule // ccd_reg_port
`default_nettype wire

// >>> bench/ccd_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_dev_model (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic [15:0] dev_addr, // register address
  input wire logic [15:0] dev_wdata, // write data
  input wire logic dev_wr, // write request level
  input wire logic dev_rd, // read request level
  output logic dev_ack, // acknowledge level
  output logic [15:0] dev_rdata // read data
);
  logic [15:0] mem [0:255];
  logic [7:0] a;
  logic [2:0] cnt;
  logic slow;
  assign a = dev_addr[7:0];
  logic ro;
  assign ro = a inside {8'h0a, 8'h0b, 8'h0c, 8'h1b, 8'h1c, 8'h26, 8'h27};
  always @(posedge sys_clk) begin
    if (!rstn) begin
      foreach (mem[i]) mem[i] = 16'h0000;
      mem[8'h00] = 16'h0002;
      mem[8'h01] = 16'h0404;
      mem[8'h02] = 16'h0011;
      mem[8'h03] = 16'h0011;
      mem[8'h04] = 16'h0011;
      mem[8'h13] = 16'h0011;
      mem[8'h14] = 16'h0011;
      mem[8'h12] = 16'h0305;
      mem[8'h20] = 16'h0005;
      mem[8'h27] = 16'h0005;
      dev_ack <= 1'b0;
      cnt <= 3'h0;
      slow <= 1'b0;
      dev_rdata <= 16'hffff;
    end else if ((dev_wr || dev_rd) && !dev_ack) begin
      cnt <= cnt + 3'h1;
      // alternate prompt and slow answers
      if (cnt == (slow ? 3'h6 : 3'h0)) begin
        cnt <= 3'h0;
        slow <= !slow;
        dev_ack <= 1'b1;
        dev_rdata <= mem[a];
        if (dev_wr && !ro) begin
          mem[a] = dev_wdata;
          if (a inside {[8'h02:8'h04], 8'h13, 8'h14})
            mem[a + 8'h08] = dev_wdata & 16'h001f;
          if (a == 8'h20) begin
            mem[8'h26] = mem[8'h22];
            mem[8'h27] = dev_wdata & 16'h000f;
          end
        end
      end
    end else if (!dev_wr && !dev_rd && dev_ack) begin
      dev_ack <= 1'b0;
      // released data no longer holds the old value
      dev_rdata <= ~dev_rdata;
    end
  end
endmodule // ccd_dev_model
`default_nettype wire

// >>> bench/tb_ccd_clock_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ccd_clock_host;
  logic sys_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_family = 1'b0, cmd_on = 1'b0;
  logic need_slow = 1'b0, cmd_ready, done, err, dev_wr, dev_rd, dev_ack, s_fam;
  logic [2:0] cmd_op = 3'h0, cmd_freq = 3'h0, cmd_index = 3'h0, s_idx;
  logic [3:0] cmd_src = 4'h0;
  logic [4:0] cmd_rate = 5'h00, cmd_div = 5'h00, s_rate, s_div;
  logic [17:0] cmd_khz = 18'h0, s_khz;
  logic [15:0] cmd_addr = 16'h0000, s_addr, rd_data, dev_addr, dev_wdata, dev_rdata;
  int err_count = 0, tests_run = 0, cycles = 0;
  always #50 sys_clk = ~sys_clk;
  ccd_clock_host ccd_clock_host_inst (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_src(cmd_src), .cmd_freq(cmd_freq),
    .cmd_family(cmd_family), .cmd_on(cmd_on), .cmd_khz(cmd_khz), .cmd_index(cmd_index),
    .cmd_rate(cmd_rate), .cmd_div(cmd_div), .cmd_addr(cmd_addr), .need_slow(need_slow),
    .done(done), .err(err), .rd_data(rd_data), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
  ccd_dev_model ccd_dev_model_inst (.sys_clk(sys_clk), .rstn(rstn), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_ack(dev_ack),
    .dev_rdata(dev_rdata));
  task automatic end_sim;
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic order(input logic [2:0] op, input logic [3:0] src, input logic [2:0] fr,
      input logic on, input logic ex);
    logic rdy;
    logic [1:0] got;
    @(posedge sys_clk);
    cmd_op <= op;
    cmd_src <= src;
    cmd_freq <= fr;
    cmd_on <= on;
    cmd_family <= s_fam;
    cmd_khz <= s_khz;
    cmd_index <= s_idx;
    cmd_rate <= s_rate;
    cmd_div <= s_div;
    cmd_addr <= s_addr;
    cmd_valid <= 1'b1;
    do begin
      @(negedge sys_clk);
      rdy = cmd_ready;
      @(posedge sys_clk);
    end while (rdy !== 1'b1);
    cmd_valid <= 1'b0;
    got = 2'b00;
    repeat (3000) if (got == 2'b00) begin
      @(negedge sys_clk);
      got = {done === 1'b1, err === 1'b1};
    end
    chk({14'h0, got}, {14'h0, !ex, ex});
  endtask
  task automatic rd(input logic [15:0] ad, input logic [15:0] ex);
    s_addr = ad;
    order(3'h7, 4'h0, 3'h0, 1'b0, 1'b0);
    chk(rd_data, ex);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    {s_fam, s_idx, s_rate, s_div, s_khz, s_addr} = '0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int s = 0; s < 16; s++)
      order(3'h0, 4'(s), 3'h2, 1'b0, !(s inside {0, 1, 2, 4, 5, 8, 9, 10, 15}));
    for (int f = 0; f < 8; f++) order(3'h1, 4'h5, 3'(f), 1'b0, f > 4);
    order(3'h1, 4'h5, 3'h4, 1'b1, 1'b0);
    order(3'h1, 4'h5, 3'h2, 1'b1, 1'b0);
    rd(16'h0112, 16'h0245);
    @(posedge sys_clk);
    need_slow <= 1'b1;
    // enable left low so only the forced need keeps the slow clock on
    for (int s = 0; s < 4; s++) order(3'h3, 4'(s), 3'h0, 1'b0, s == 3);
    rd(16'h0100, 16'h0042);
    s_fam = 1'b1;
    order(3'h0, 4'h1, 3'h3, 1'b1, 1'b0);
    rd(16'h0101, 16'h8341);
    s_div = 5'h04;
    order(3'h5, 4'h0, 3'h3, 1'b1, 1'b0);
    rd(16'h0149, 16'h8023);
    order(3'h0, 4'h1, 3'h2, 1'b1, 1'b0);
    rd(16'h0101, 16'h8241);
    order(3'h5, 4'h0, 3'h3, 1'b1, 1'b1);
    order(3'h5, 4'h0, 3'h4, 1'b1, 1'b1);
    s_div = 5'h05;
    order(3'h5, 4'h0, 3'h1, 1'b1, 1'b1);
    s_idx = 3'h1;
    s_div = 5'h1e;
    order(3'h5, 4'h0, 3'h3, 1'b1, 1'b1);
    order(3'h5, 4'h0, 3'h2, 1'b1, 1'b0);
    rd(16'h014a, 16'h80f2);
    s_khz = 18'h1_8000;
    order(3'h2, 4'h4, 3'h0, 1'b1, 1'b0);
    chk(rd_data, 16'h1893);
    rd(16'h0127, 16'h0004);
    s_khz = 18'h2_4220;
    order(3'h2, 4'h4, 3'h0, 1'b1, 1'b0);
    chk(rd_data, 16'h2500);
    s_khz = 18'h2_4230;
    order(3'h2, 4'h4, 3'h0, 1'b1, 1'b1);
    s_khz = 18'h15d6;
    order(3'h2, 4'h0, 3'h0, 1'b1, 1'b1);
    s_khz = 18'h15e0;
    order(3'h2, 4'h0, 3'h0, 1'b1, 1'b0);
    chk(rd_data, 16'h0166);
    order(3'h2, 4'h3, 3'h0, 1'b1, 1'b1);
    s_idx = 3'h0;
    s_rate = 5'h0b;
    order(3'h4, 4'h0, 3'h0, 1'b0, 1'b0);
    chk(rd_data, 16'h000b);
    s_rate = 5'h07;
    order(3'h4, 4'h0, 3'h0, 1'b0, 1'b1);
    s_rate = 5'h13;
    s_idx = 3'h4;
    order(3'h4, 4'h0, 3'h0, 1'b0, 1'b0);
    chk(rd_data, 16'h0013);
    s_idx = 3'h5;
    order(3'h4, 4'h0, 3'h0, 1'b0, 1'b1);
    rd(16'h010b, 16'h0000);
    order(3'h6, 4'h0, 3'h0, 1'b1, 1'b0);
    rd(16'h014e, 16'h0200);
    end_sim();
  end
endmodule // tb_ccd_clock_host
`default_nettype wire
